//--- logic/wwcm_pkg.sv
package wwcm_pkg;

    // ****************************************
    // service register layout
    // ****************************************
    localparam int SEL_HI = 7;
    localparam int SEL_LO = 6;
    localparam int KEY_HI = 5;
    localparam int KEY_LO = 1;
    localparam int CM_BIT = 0;
    localparam logic [4:0] KEY_VAL = 5'h0c;
    localparam logic [4:0] KEY_READ = 5'h00;
    localparam logic [1:0] RST_SEL = 2'h3;
    localparam logic RST_CM_EN = 1'b1;

    // ****************************************
    // window timing, in idle timer ticks, or in low speed ticks when i_low_speed is set
    // ****************************************
    localparam int CNT_W = 17;
    localparam logic [CNT_W-1:0] LOWER_TICKS = 17'h00800;
    localparam logic [CNT_W-1:0] UPPER_BASE = 17'h02000;

    // ****************************************
    // fault pin and clock monitor timing
    // ****************************************
    localparam logic [5:0] HOLD_CYC = 6'h10;
    localparam int CLK_KHZ = 40000;
    // longest allowed gap between clock edges; 5 kHz toggles every 100 us
    localparam int CM_TIME_US = 200;
    localparam int CM_CYC = (CM_TIME_US * CLK_KHZ) / 1000;
    localparam int CM_W = 14;

    function automatic logic [CNT_W-1:0] upper_limit(input logic [1:0] sel);
        upper_limit = UPPER_BASE << sel;
    endfunction

endpackage

//--- logic/wwcm_sync.sv
`timescale 1ns/10ps
module wwcm_sync (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic i_async,
    output logic o_sync
);

    // ****************************************
    // two stage synchroniser
    // ****************************************
    logic meta_ff;
    logic sync_ff;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else if (i_ce) begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;

endmodule

//--- logic/wwcm_watchdog.sv
`timescale 1ns/10ps
module wwcm_watchdog #(
    parameter int CM_CYC = wwcm_pkg::CM_CYC
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic i_wd_option_en,
    input wire logic i_low_speed,
    input wire logic i_idle_tick,
    input wire logic i_ls_tick,
    input wire logic i_tc_clk,
    input wire logic i_wr_en,
    input wire logic [7:0] i_wr_data,
    input wire logic i_rd_en,
    input wire logic i_fault_pin,
    output logic [7:0] o_rd_data,
    output logic o_wd_fault_out_o,
    output logic o_wd_fault_out_oe,
    output logic o_wd_error,
    output logic o_cm_error
);

    typedef enum logic [1:0] {ST_RUN, ST_DRIVE, ST_HOLD, ST_RELEASE} wwcm_st_e;

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic pin_s;
    logic tc_s;

    wwcm_sync u_pin_sync (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_async(i_fault_pin),
        .o_sync(pin_s)
    );

    wwcm_sync u_tc_sync (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_async(i_tc_clk),
        .o_sync(tc_s)
    );

    // ****************************************
    // state
    // ****************************************
    wwcm_st_e st_ff;
    wwcm_st_e nxt_st;
    logic [1:0] sel_ff;
    logic cm_en_ff;
    logic configured_ff;
    logic [wwcm_pkg::CNT_W-1:0] cnt_ff;
    logic [wwcm_pkg::CNT_W-1:0] nxt_cnt;
    logic [5:0] hold_ff;
    logic [5:0] nxt_hold;
    logic tc_d_ff;
    logic [wwcm_pkg::CM_W-1:0] cm_cnt_ff;
    logic [wwcm_pkg::CM_W-1:0] nxt_cm_cnt;
    logic [7:0] rd_data_ff;
    logic oe_ff;
    logic fault_o_ff;
    logic wd_error_ff;
    logic cm_error_ff;

    // ****************************************
    // decode
    // ****************************************
    wire logic tick;
    wire logic [1:0] wr_sel;
    wire logic [4:0] wr_key;
    wire logic wr_cm;
    wire logic key_ok;
    wire logic full_ok;
    wire logic [wwcm_pkg::CNT_W-1:0] upper;
    wire logic early;
    wire logic expire;
    wire logic in_run;
    wire logic svc_wr;
    wire logic svc_ok;
    wire logic cfg_wr;
    wire logic restart;
    wire logic wd_err;
    wire logic tc_edge;
    wire logic [wwcm_pkg::CM_W-1:0] cm_last;
    wire logic cm_slow;
    wire logic cm_err;
    wire logic hold_done;

    // the low speed tick comes from the 32 kHz clock instead of t_c
    assign tick = i_low_speed ? i_ls_tick : i_idle_tick;
    assign wr_sel = i_wr_data[wwcm_pkg::SEL_HI:wwcm_pkg::SEL_LO];
    assign wr_key = i_wr_data[wwcm_pkg::KEY_HI:wwcm_pkg::KEY_LO];
    assign wr_cm = i_wr_data[wwcm_pkg::CM_BIT];
    assign key_ok = (wr_key == wwcm_pkg::KEY_VAL);
    assign full_ok = key_ok && (wr_sel == sel_ff) &&
                     (wr_cm == cm_en_ff);
    assign upper = wwcm_pkg::upper_limit(sel_ff);
    // lower limit logic stands apart from the upper limit compare
    assign early = (cnt_ff < wwcm_pkg::LOWER_TICKS);
    assign expire = tick && (cnt_ff == upper - 17'h00001);
    assign in_run = (st_ff == ST_RUN) && i_wd_option_en;
    // a write while the fault pin is driven is ignored
    assign svc_wr = in_run && i_wr_en;
    // the first write may land inside the lower limit
    assign svc_ok = configured_ff ? (full_ok && !early) :
                    key_ok;
    assign cfg_wr = svc_wr && !configured_ff && key_ok;
    assign restart = svc_wr && svc_ok;
    assign wd_err = (svc_wr && !svc_ok) || (in_run && expire);

    // ****************************************
    // clock monitor
    // ****************************************
    assign tc_edge = tc_s ^ tc_d_ff;
    assign cm_last = wwcm_pkg::CM_W'(CM_CYC - 1);
    // saturating gap counter; any t_c edge clears it
    assign cm_slow = (cm_cnt_ff == cm_last);
    assign nxt_cm_cnt = tc_edge ? '0 :
                        (cm_slow ? cm_cnt_ff : cm_cnt_ff + 14'h0001);
    assign cm_err = cm_slow && cm_en_ff && i_wd_option_en;

    // ****************************************
    // window counter
    // ****************************************
    assign nxt_cnt = (restart || (st_ff == ST_RELEASE)) ? '0 :
                     ((in_run && tick) ? cnt_ff + 17'h00001 : cnt_ff);

    // ****************************************
    // fault sequence
    // ****************************************
    assign hold_done = (hold_ff == wwcm_pkg::HOLD_CYC - 6'h01);
    // monitor error keeps the hold counter at zero until the clock returns
    assign nxt_hold = (st_ff != ST_HOLD || cm_err) ? 6'h00 :
                      (hold_done ? hold_ff : hold_ff + 6'h01);

    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            ST_RUN: begin
                if (wd_err || cm_err) begin
                    nxt_st = ST_DRIVE;
                end
            end
            ST_DRIVE: begin
                if (!pin_s) begin
                    nxt_st = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (hold_done && !cm_err) begin
                    nxt_st = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                if (pin_s) begin
                    nxt_st = ST_RUN;
                end
            end
        endcase
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_ff <= ST_RUN;
            sel_ff <= wwcm_pkg::RST_SEL;
            cm_en_ff <= wwcm_pkg::RST_CM_EN;
            configured_ff <= 1'b0;
            cnt_ff <= '0;
            hold_ff <= 6'h00;
        end else if (i_ce) begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            hold_ff <= nxt_hold;
            if (cfg_wr) begin
                sel_ff <= wr_sel;
                cm_en_ff <= wr_cm;
                configured_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tc_d_ff <= 1'b0;
            cm_cnt_ff <= '0;
        end else if (i_ce) begin
            tc_d_ff <= tc_s;
            cm_cnt_ff <= nxt_cm_cnt;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rd_data_ff <= 8'h00;
            oe_ff <= 1'b0;
            fault_o_ff <= 1'b0;
            wd_error_ff <= 1'b0;
            cm_error_ff <= 1'b0;
        end else if (i_ce) begin
            if (i_rd_en) begin
                // key never reads back
                rd_data_ff <= {sel_ff, wwcm_pkg::KEY_READ, cm_en_ff};
            end
            oe_ff <= (nxt_st == ST_DRIVE) || (nxt_st == ST_HOLD);
            fault_o_ff <= 1'b0;
            wd_error_ff <= (st_ff == ST_RUN) && wd_err;
            cm_error_ff <= cm_err;
        end
    end

    assign o_rd_data = rd_data_ff;
    assign o_wd_fault_out_o = fault_o_ff;
    assign o_wd_fault_out_oe = oe_ff;
    assign o_wd_error = wd_error_ff;
    assign o_cm_error = cm_error_ff;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    property p_opt_off;
        !i_wd_option_en && st_ff == ST_RUN && i_ce |=> !o_wd_fault_out_oe;
    endproperty
    a_opt_off: assert property (p_opt_off)
        else $error("fault without option");

    property p_early;
        i_ce && in_run && configured_ff && i_wr_en && early
            |=> st_ff == ST_DRIVE;
    endproperty
    a_early: assert property (p_early)
        else $error("early service missed");

    sequence s_fault_start;
        st_ff == ST_DRIVE && o_wd_fault_out_oe ##1 o_wd_fault_out_oe;
    endsequence
    property p_bad_key;
        i_ce && in_run && i_wr_en && !key_ok |=> s_fault_start;
    endproperty
    a_bad_key: assert property (p_bad_key)
        else $error("bad key missed");

    property p_expire;
        i_ce && in_run && tick && cnt_ff == upper - 17'h00001
            |=> st_ff == ST_DRIVE && o_wd_fault_out_oe;
    endproperty
    a_expire: assert property (p_expire)
        else $error("expiry missed");

    property p_restart;
        i_ce && restart |=> cnt_ff == '0;
    endproperty
    a_restart: assert property (p_restart)
        else $error("no restart");

    property p_cfg_frozen;
        configured_ff |=> $stable(sel_ff) && $stable(cm_en_ff);
    endproperty
    a_cfg_frozen: assert property (p_cfg_frozen)
        else $error("config changed");

    sequence s_hold_entry;
        i_ce && st_ff == ST_DRIVE && !pin_s;
    endsequence
    sequence s_hold_low;
        o_wd_fault_out_oe [*8];
    endsequence
    property p_hold;
        s_hold_entry |=> s_hold_low;
    endproperty
    a_hold: assert property (p_hold)
        else $error("fault released early");

    property p_cm_off;
        i_ce && !cm_en_ff |=> !o_cm_error;
    endproperty
    a_cm_off: assert property (p_cm_off)
        else $error("monitor not disabled");

    property p_cm_edge;
        i_ce && tc_edge |=> cm_cnt_ff == '0 && !cm_slow;
    endproperty
    a_cm_edge: assert property (p_cm_edge)
        else $error("edge not seen");

    property p_window;
        i_ce && st_ff == ST_RUN && !restart && tick && i_wd_option_en
            && !expire |=> cnt_ff == $past(cnt_ff) + 17'h00001;
    endproperty
    a_window: assert property (p_window)
        else $error("tick not counted");

endmodule

//--- verif/windowed_watchdog_clock_monitor_tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module windowed_watchdog_clock_monitor_tb_top;
    // ****************************
    // stimulus and open-drain pin
    // ****************************
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_ce = 1'b1;
    logic i_wd_option_en = 1'b1;
    logic i_low_speed = 1'b0;
    logic i_idle_tick = 1'b0;
    logic i_ls_tick = 1'b0;
    logic i_tc_clk = 1'b0;
    logic i_wr_en = 1'b0;
    logic [7:0] i_wr_data = 8'h00;
    logic i_rd_en = 1'b0;
    logic [7:0] o_rd_data;
    logic o_wd_fault_out_o;
    logic o_wd_fault_out_oe;
    logic o_wd_error;
    logic o_cm_error;
    logic hs_on = 1'b0;
    logic ls_on = 1'b0;
    logic tc_run = 1'b1;
    int error_cnt = 0;
    int comparisons = 0;
    // weak pull-up: pin reads high unless the block sinks it
    wire logic i_fault_pin = o_wd_fault_out_oe ? o_wd_fault_out_o : 1'b1;

    always #12.5 i_clk = ~i_clk;

    always @(posedge i_clk) begin
        i_idle_tick <= hs_on;
        i_ls_tick <= ls_on;
        if (tc_run) begin
            i_tc_clk <= ~i_tc_clk;
        end
    end

    // small gap so a stopped clock is caught in a few dozen cycles
    wwcm_watchdog #(.CM_CYC(20)) i_wwcm_watchdog (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce),
        .i_wd_option_en(i_wd_option_en), .i_low_speed(i_low_speed),
        .i_idle_tick(i_idle_tick), .i_ls_tick(i_ls_tick),
        .i_tc_clk(i_tc_clk), .i_wr_en(i_wr_en), .i_wr_data(i_wr_data),
        .i_rd_en(i_rd_en), .i_fault_pin(i_fault_pin),
        .o_rd_data(o_rd_data), .o_wd_fault_out_o(o_wd_fault_out_o),
        .o_wd_fault_out_oe(o_wd_fault_out_oe), .o_wd_error(o_wd_error),
        .o_cm_error(o_cm_error));

    // ****************************
    // shared tasks
    // ****************************
    function automatic logic sig(input int w);
        case (w)
            0: sig = o_wd_fault_out_oe;
            1: sig = o_wd_error;
            default: sig = o_cm_error;
        endcase
    endfunction

    task automatic final_report();
        $display("counts: %0d compares, %0d mismatches", comparisons,
            error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic wait_sig(input int w, input logic v, input int max,
        output int n);
        n = 0;
        #1;
        while (sig(w) !== v) begin
            @(posedge i_clk);
            #1;
            n++;
            if (n > max) begin
                error_cnt++;
                $display("mismatch wait %0d expected %b seen timeout", w, v);
                final_report();
            end
        end
    endtask

    task automatic hits(input int w, input int cyc, output int h);
        h = 0;
        // look before the first edge so a one-cycle pulse is not missed
        repeat (cyc) begin
            #1;
            if (sig(w) !== 1'b0) begin
                h++;
            end
            @(posedge i_clk);
        end
    endtask

    task automatic do_reset(input logic opt, input logic ls);
        @(posedge i_clk);
        i_resetn <= 1'b0;
        i_wd_option_en <= opt;
        i_low_speed <= ls;
        hs_on <= ~ls;
        ls_on <= ls;
        tc_run <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_resetn <= 1'b1;
        @(posedge i_clk);
    endtask

    task automatic wr(input logic [7:0] d);
        @(posedge i_clk);
        i_wr_en <= 1'b1;
        i_wr_data <= d;
        @(posedge i_clk);
        i_wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] exp);
        @(posedge i_clk);
        i_rd_en <= 1'b1;
        @(posedge i_clk);
        i_rd_en <= 1'b0;
        @(posedge i_clk);
        #1;
        `CHK("rd_data", exp, o_rd_data)
    endtask

    // pin follows the sink; hold must end 16..32 cycles after it falls
    task automatic fault_cycle();
        int n;
        wait_sig(0, 1'b1, 4, n);
        `CHK("fault_o", 1'b0, o_wd_fault_out_o)
        wait_sig(0, 1'b0, 60, n);
        `CHK("hold_len", 1'b1, n >= 16 && n <= 32)
        repeat (5) @(posedge i_clk);
    endtask

    task automatic expect_err(input logic [7:0] d, input logic e);
        int n;
        wr(d);
        if (e) begin
            wait_sig(1, 1'b1, 4, n);
            fault_cycle();
        end else begin
            hits(1, 6, n);
            `CHK("no_error", 0, n)
        end
    endtask

    // ****************************
    // scenarios
    // ****************************
    task automatic t_basic();
        do_reset(1'b1, 1'b0);
        rd(8'hc1);
        `CHK("oe_idle", 1'b0, o_wd_fault_out_oe)
        expect_err(8'h19, 1'b0);
        rd(8'h01);
        repeat (2060) @(posedge i_clk);
        expect_err(8'h19, 1'b0);
        repeat (2030) @(posedge i_clk);
        expect_err(8'h19, 1'b1);
        $display("test basic done");
    endtask

    task automatic t_window();
        int n;
        logic [7:0] bad [3] = '{8'h1b, 8'h59, 8'h18};
        foreach (bad[i]) begin
            repeat (2060) @(posedge i_clk);
            expect_err(bad[i], 1'b1);
        end
        wait_sig(1, 1'b1, 9000, n);
        `CHK("upper_8k", 1'b1, n >= 8180 && n <= 8200)
        fault_cycle();
        $display("test window done");
    endtask

    task automatic t_low_speed();
        int n;
        do_reset(1'b1, 1'b1);
        expect_err(8'h59, 1'b0);
        wait_sig(1, 1'b1, 17000, n);
        `CHK("upper_16k", 1'b1, n >= 16360 && n <= 16392)
        fault_cycle();
        $display("test low speed done");
    endtask

    task automatic t_monitor();
        int n;
        do_reset(1'b1, 1'b0);
        hits(2, 100, n);
        `CHK("cm_quiet", 0, n)
        @(posedge i_clk);
        tc_run <= 1'b0;
        wait_sig(2, 1'b1, 40, n);
        // gap of 20 cycles plus sync and edge detect
        `CHK("cm_delay", 1'b1, n >= 20 && n <= 26)
        `CHK("cm_sink", 1'b1, o_wd_fault_out_oe)
        @(posedge i_clk);
        tc_run <= 1'b1;
        wait_sig(2, 1'b0, 40, n);
        wait_sig(0, 1'b0, 80, n);
        do_reset(1'b1, 1'b0);
        expect_err(8'h18, 1'b0);
        @(posedge i_clk);
        tc_run <= 1'b0;
        hits(2, 60, n);
        `CHK("cm_off", 0, n)
        $display("test monitor done");
    endtask

    task automatic t_option();
        int n;
        do_reset(1'b0, 1'b0);
        @(posedge i_clk);
        tc_run <= 1'b0;
        wr(8'h00);
        hits(0, 60, n);
        `CHK("option_off", 0, n)
        $display("test option done");
    endtask

    // i_ce low for 100 cycles must stretch the window by that, to within the 20-cycle upper_32k band
    task automatic t_upper32();
        int n;
        do_reset(1'b1, 1'b0);
        expect_err(8'h99, 1'b0);
        @(posedge i_clk);
        i_ce <= 1'b0;
        repeat (100) @(posedge i_clk);
        i_ce <= 1'b1;
        wait_sig(1, 1'b1, 33000, n);
        `CHK("upper_32k", 1'b1, n >= 32750 && n <= 32770)
        fault_cycle();
        $display("test upper 32k done");
    endtask

    initial begin
        t_basic();
        t_window();
        t_low_speed();
        t_monitor();
        t_option();
        t_upper32();
        final_report();
    end
endmodule
